// [inc/pwe_pkg.sv]
// Constants and types of the programmable waveform engine
package pwe_pkg;
  // ==========================================================
  // Register map
  localparam int ADDR_W = 16;
  localparam logic [15:0] MEM_BASE = 16'he400;
  localparam logic [15:0] TRIG_ADDR = 16'he480;
  localparam logic [15:0] ISC_ADDR = 16'he481;
  localparam logic [15:0] ICL_ADDR = 16'he482;
  localparam logic [15:0] CCFG_ADDR = 16'he483;
  localparam logic [15:0] ABORT_ADDR = 16'he484;
  localparam logic [15:0] WFSEL_ADDR = 16'he485;
  localparam logic [15:0] IFSEL_ADDR = 16'he486;
  localparam logic [15:0] READY_ADDR = 16'he487;
  localparam logic [15:0] ADRL_ADDR = 16'he488;
  localparam logic [15:0] ADRH_ADDR = 16'he489;
  localparam logic [15:0] DOL_ADDR = 16'he48a;
  localparam logic [15:0] DOH_ADDR = 16'he48b;
  localparam logic [15:0] DIL_ADDR = 16'he48c;
  localparam logic [15:0] DIH_ADDR = 16'he48d;
  localparam logic [15:0] TCNT_ADDR = 16'he48e;
  localparam int MEM_BYTES = 128;
  // ==========================================================
  // Reset values
  localparam logic [7:0] ISC_RST = 8'h00;
  localparam logic [7:0] ICL_RST = 8'hff;
  localparam logic [7:0] CCFG_RST = 8'h00;
  localparam logic [7:0] WFSEL_RST = 8'he4;
  localparam logic [1:0] IFSEL_RST = 2'h0;
  localparam logic [1:0] IFSEL_WAVE = 2'h2;
  // ==========================================================
  // Fields
  localparam int DONE_BIT = 7;
  localparam int IDRV_BIT = 0;
  localparam int TRI_MODE_BIT = 7;
  localparam int INT_READY_BIT = 7;
  localparam int I_DEC = 7;
  localparam int I_REEX = 6;
  localparam int I_DATA = 5;
  localparam int I_FADV = 4;
  localparam int I_AINC = 3;
  localparam int I_WINT = 2;
  localparam int I_ARG = 8;
  localparam int I_TERMS = 16;
  localparam int I_CTL = 24;
  localparam logic [2:0] LAST_ST = 3'h6;
  localparam logic [2:0] IDLE_ST = 3'h7;
  localparam logic [1:0] LF_AND = 2'h0;
  localparam logic [1:0] LF_OR = 2'h1;
  localparam logic [1:0] LF_XOR = 2'h2;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_RUN = 2'b10
  } pwe_phase_t;
endpackage

// [hw/pwe_top.sv]
// Programmable waveform engine with its register port
`timescale 1ns/10ps
`default_nettype none
module pwe_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [pwe_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // Peripheral inputs
  input wire logic [5:0] i_ready,
  input wire logic i_fifo_flag,
  input wire logic [15:0] i_dbus_in,
  // Peripheral outputs
  output logic [15:0] o_dbus_out,
  output logic o_dbus_oe,
  output logic [5:0] o_ctl_out,
  output logic [5:0] o_ctl_oe,
  output logic [8:0] o_addr,
  // Events and status
  output logic o_fifo_adv,
  output logic o_wave_int,
  output logic o_done_int,
  output logic o_done,
  output logic [2:0] o_state
);
  import pwe_pkg::*;

  // ==========================================================
  // Storage and synchronisers
  logic [7:0] mem [MEM_BYTES];
  logic [5:0] rdy_s1, rdy_s2;
  logic ff_s1, ff_s2;
  logic [15:0] dbus_s1, dbus_s2;
  logic [7:0] isc_reg, icl_reg, ccfg_reg, wfsel_reg, rdyreg_reg, tc_reg;
  logic [1:0] ifsel_reg, type_reg, desc_reg;
  logic [15:0] dout_reg, din_reg;
  logic [31:0] instr_reg;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] st_reg, st_next, tgt;
  pwe_phase_t phase_reg, phase_next;
  logic enter;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdy_s1 <= 6'h00;
      rdy_s2 <= 6'h00;
      ff_s1 <= 1'b0;
      ff_s2 <= 1'b0;
      dbus_s1 <= 16'h0000;
      dbus_s2 <= 16'h0000;
    end else begin
      rdy_s1 <= i_ready;
      rdy_s2 <= rdy_s1;
      ff_s1 <= i_fifo_flag;
      ff_s2 <= ff_s1;
      dbus_s1 <= i_dbus_in;
      dbus_s2 <= dbus_s1;
    end
  end

  // ==========================================================
  // Register decode
  wire idle = (phase_reg == PH_IDLE);
  wire mode_ok = (ifsel_reg == IFSEL_WAVE);
  wire in_mem = (i_addr[15:7] == MEM_BASE[15:7]);
  wire wr_cfg = i_wr && idle;
  // Descriptor bytes hidden outside waveform mode
  wire wr_mem = wr_cfg && in_mem && mode_ok;
  wire abort_wr = i_wr && (i_addr == ABORT_ADDR);
  // A trigger while busy is dropped, never queued
  wire trig_go = wr_cfg && (i_addr == TRIG_ADDR) && mode_ok;
  wire [1:0] trig_type = i_wr_data[1:0];
  wire [1:0] desc_sel = wfsel_reg[{trig_type, 1'b0} +: 2];
  wire [1:0] desc_next = trig_go ? desc_sel : desc_reg;
  // Instruction fetched for the state about to be entered
  wire [6:0] fidx = {desc_next, tgt, 2'b00};
  wire [31:0] instr_tgt = {mem[fidx + 7'd3], mem[fidx + 7'd2],
                           mem[fidx + 7'd1], mem[fidx]};
  wire [31:0] instr_next = enter ? instr_tgt : instr_reg;
  wire is_read = type_reg[0];

  always_ff @(posedge i_clk) begin
    if (wr_mem) begin
      mem[i_addr[6:0]] <= i_wr_data;
    end
  end

  // ==========================================================
  // Decision terms
  wire tc_expired = (tc_reg == 8'h00);
  wire [8:0] terms = {tc_expired, rdyreg_reg[INT_READY_BIT], ff_s2, rdy_s2};
  wire [3:0] sel_a = instr_reg[I_TERMS +: 4];
  wire [3:0] sel_b = instr_reg[I_TERMS+4 +: 4];
  wire term_a = (sel_a < 4'd9) ? terms[sel_a] : 1'b0;
  wire term_b = (sel_b < 4'd9) ? terms[sel_b] : 1'b0;
  wire [1:0] lfunc = instr_reg[I_ARG+6 +: 2];
  wire lres = (lfunc == LF_AND) ? (term_a & term_b) :
              (lfunc == LF_OR) ? (term_a | term_b) :
              (lfunc == LF_XOR) ? (term_a ^ term_b) : 1'b0;
  wire [2:0] br1 = instr_reg[I_ARG +: 3];
  wire [2:0] br0 = instr_reg[I_ARG+3 +: 3];

  // ==========================================================
  // Sequencer
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    tgt = st_reg;
    enter = 1'b0;
    unique case (phase_reg)
      PH_IDLE: begin
        if (trig_go) begin
          phase_next = PH_RUN;
          tgt = 3'h0;
          enter = 1'b1;
        end
      end
      PH_RUN: begin
        if (abort_wr) begin
          phase_next = PH_IDLE;
        end else if (instr_reg[I_DEC]) begin
          // Branch one edge after entry at the earliest
          tgt = lres ? br1 : br0;
          if (tgt == IDLE_ST) begin
            phase_next = PH_IDLE;
          end else if (tgt != st_reg || instr_reg[I_REEX]) begin
            enter = 1'b1;
          end
        end else if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else if (st_reg == LAST_ST) begin
          phase_next = PH_IDLE;
        end else begin
          tgt = st_reg + 3'h1;
          enter = 1'b1;
        end
      end
      default: phase_next = PH_IDLE;
    endcase
    // Delay byte 0 wraps to 255, giving 256 clocks
    if (enter) begin
      cnt_next = instr_tgt[I_ARG +: 8] - 8'h01;
    end
    st_next = (phase_next == PH_IDLE) ? IDLE_ST : tgt;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= PH_IDLE;
      st_reg <= IDLE_ST;
      cnt_reg <= 8'h00;
      instr_reg <= 32'h0000_0000;
      desc_reg <= 2'h0;
      type_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      instr_reg <= instr_next;
      desc_reg <= desc_next;
      if (trig_go) begin
        type_reg <= trig_type;
      end
    end
  end

  // ==========================================================
  // Software registers
  wire task_fadv = enter && instr_tgt[I_FADV];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      isc_reg <= ISC_RST;
      icl_reg <= ICL_RST;
      ccfg_reg <= CCFG_RST;
      wfsel_reg <= WFSEL_RST;
      ifsel_reg <= IFSEL_RST;
      rdyreg_reg <= 8'h00;
      dout_reg <= 16'h0000;
      din_reg <= 16'h0000;
      tc_reg <= 8'h00;
      o_addr <= 9'h000;
    end else begin
      if (wr_cfg) begin
        unique case (i_addr)
          ISC_ADDR: isc_reg <= i_wr_data;
          ICL_ADDR: icl_reg <= i_wr_data;
          CCFG_ADDR: ccfg_reg <= i_wr_data;
          WFSEL_ADDR: wfsel_reg <= i_wr_data;
          IFSEL_ADDR: ifsel_reg <= i_wr_data[1:0];
          READY_ADDR: rdyreg_reg <= i_wr_data;
          ADRL_ADDR: o_addr[7:0] <= i_wr_data;
          ADRH_ADDR: o_addr[8] <= i_wr_data[0];
          DOL_ADDR: dout_reg[7:0] <= i_wr_data;
          DOH_ADDR: dout_reg[15:8] <= i_wr_data;
          TCNT_ADDR: tc_reg <= i_wr_data;
          default: ;
        endcase
      end
      if (enter && instr_tgt[I_AINC]) begin
        o_addr <= o_addr + 9'h001;
      end
      if (task_fadv && !tc_expired) begin
        tc_reg <= tc_reg - 8'h01;
      end
      if (enter && instr_tgt[I_DATA] && is_read) begin
        din_reg <= dbus_s2;
      end
    end
  end

  // ==========================================================
  // Pin drive, computed from the next state so pins move with it
  wire go_idle = (phase_next == PH_IDLE);
  wire [7:0] lvl = go_idle ? icl_reg : instr_next[I_CTL +: 8];
  wire ctl_tri_mode = ccfg_reg[TRI_MODE_BIT];
  // Open-drain outputs only pull low
  wire [5:0] oe_cmos = ~(ccfg_reg[5:0] & lvl[5:0]);
  wire [5:0] ctl_oe = ctl_tri_mode ? {2'b00, lvl[7:4]} : oe_cmos;
  wire [5:0] ctl_out = ctl_tri_mode ? {2'b00, lvl[3:0]} : lvl[5:0];
  wire drive = !is_read && instr_next[I_DATA];
  wire dbus_oe = go_idle ? isc_reg[IDRV_BIT] : drive;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctl_out <= 6'h00;
      o_ctl_oe <= 6'h00;
      o_dbus_oe <= 1'b0;
      o_dbus_out <= 16'h0000;
      o_fifo_adv <= 1'b0;
      o_wave_int <= 1'b0;
      o_done_int <= 1'b0;
      o_done <= 1'b1;
      o_state <= IDLE_ST;
    end else begin
      o_ctl_out <= ctl_out;
      o_ctl_oe <= ctl_oe;
      o_dbus_oe <= dbus_oe;
      if (!go_idle && drive) begin
        o_dbus_out <= dout_reg;
      end
      o_fifo_adv <= task_fadv;
      o_wave_int <= enter && instr_tgt[I_WINT];
      o_done_int <= !idle && go_idle;
      o_done <= go_idle;
      o_state <= st_next;
    end
  end

  // ==========================================================
  // Read port, data stands one cycle after the strobe
  logic [7:0] rd_mux;
  wire [7:0] done_byte = {o_done, 7'h00};
  always_comb begin
    rd_mux = 8'h00;
    if (in_mem) begin
      rd_mux = mode_ok ? mem[i_addr[6:0]] : 8'h00;
    end else begin
      unique case (i_addr)
        TRIG_ADDR: rd_mux = done_byte | {6'h00, type_reg};
        ISC_ADDR: rd_mux = done_byte | {1'b0, isc_reg[6:0]};
        ICL_ADDR: rd_mux = icl_reg;
        CCFG_ADDR: rd_mux = ccfg_reg;
        WFSEL_ADDR: rd_mux = wfsel_reg;
        IFSEL_ADDR: rd_mux = {6'h00, ifsel_reg};
        READY_ADDR: rd_mux = rdyreg_reg;
        ADRL_ADDR: rd_mux = o_addr[7:0];
        ADRH_ADDR: rd_mux = {7'h00, o_addr[8]};
        DOL_ADDR: rd_mux = dout_reg[7:0];
        DOH_ADDR: rd_mux = dout_reg[15:8];
        DIL_ADDR: rd_mux = din_reg[7:0];
        DIH_ADDR: rd_mux = din_reg[15:8];
        TCNT_ADDR: rd_mux = tc_reg;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================
  // Checks
  chk_done_phase: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done == idle) else $error("done flag disagrees with phase");
  chk_abort_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    (!idle && abort_wr) |=> (idle && o_done && o_state == IDLE_ST))
    else $error("abort did not force idle");
  chk_trig_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    (idle && i_wr && i_addr == TRIG_ADDR && !mode_ok) |=> idle)
    else $error("trigger accepted outside waveform mode");
  chk_ndp_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!idle && !instr_reg[I_DEC] && cnt_reg != 8'h00 && !abort_wr)
    |=> ($stable(st_reg) && cnt_reg == $past(cnt_reg) - 8'h01))
    else $error("fixed-delay state left early");
  chk_s6_fall: assert property (@(posedge i_clk) disable iff (i_rst)
    (!idle && !instr_reg[I_DEC] && cnt_reg == 8'h00 && st_reg == LAST_ST)
    |=> o_done) else $error("last state did not reach idle");
  chk_task_once: assert property (@(posedge i_clk) disable iff (i_rst)
    (!idle && !abort_wr && instr_reg[I_DEC] && !instr_reg[I_REEX]
     && (lres ? br1 : br0) == st_reg) |=> !o_fifo_adv)
    else $error("task repeated without re-execute");
  chk_addr_inc: assert property (@(posedge i_clk) disable iff (i_rst)
    (enter && instr_tgt[I_AINC]) |=> o_addr == $past(o_addr) + 9'h001)
    else $error("address did not increment");
  chk_idle_data: assert property (@(posedge i_clk) disable iff (i_rst)
    (idle && $past(idle) && $stable(isc_reg)) |-> o_dbus_oe == isc_reg[IDRV_BIT])
    else $error("idle data drive wrong");
  // Pins still hold reset values one edge after release
  chk_idle_tri: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && idle && $past(idle) && $stable(icl_reg) && $stable(ccfg_reg)
     && ctl_tri_mode)
    |-> (o_ctl_oe == {2'b00, icl_reg[7:4]} && o_ctl_out[5:4] == 2'b00))
    else $error("tristate idle controls wrong");
  chk_idle_cmos: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && idle && $past(idle) && $stable(icl_reg) && $stable(ccfg_reg)
     && !ctl_tri_mode && ccfg_reg[5:0] == 6'h00)
    |-> (o_ctl_oe == 6'h3f && o_ctl_out == icl_reg[5:0]))
    else $error("idle controls wrong");
endmodule
`default_nettype wire

// [bench/pwe_periph.sv]
// Peripheral model on the far side of the waveform engine
`timescale 1ns/10ps
`default_nettype none
module pwe_periph (
  // Clock
  input wire logic i_clk,
  // From engine, and ready requests from the bench
  input wire logic [15:0] i_dbus_out,
  input wire logic i_dbus_oe,
  input wire logic [5:0] i_ready_req,
  // To engine
  output logic [5:0] o_ready,
  output logic [15:0] o_dbus_in
);
  logic [15:0] float_pat = 16'h0000;
  // ==========================================================
  // Data bus
  // Released bus never shows a held value; a fixed 0 or 1 would hide faults
  always @(posedge i_clk) begin
    float_pat <= float_pat + 16'h9e37;
  end
  assign o_dbus_in = i_dbus_oe ? i_dbus_out : float_pat;
  // Ready lines follow what the bench commands
  assign o_ready = i_ready_req;
endmodule
`default_nettype wire

// [bench/tb.sv]
// Register-level testbench of the waveform engine
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pwe_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [5:0] ready_req = 6'h00;
  logic fifo_flag = 1'b0;
  logic [7:0] o_rd_data;
  logic [5:0] i_ready;
  logic [15:0] i_dbus_in;
  logic [15:0] o_dbus_out;
  logic o_dbus_oe;
  logic [8:0] o_addr;
  logic o_fifo_adv;
  logic o_wave_int;
  logic [5:0] o_ctl_out;
  logic [5:0] o_ctl_oe;
  logic o_done_int;
  logic o_done;
  logic [2:0] o_state;
  logic [2:0] exp_st [9] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #5 i_clk = ~i_clk;
  pwe_top i_pwe_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_ready(i_ready),
    .i_fifo_flag(fifo_flag), .i_dbus_in(i_dbus_in), .o_dbus_out(o_dbus_out),
    .o_dbus_oe(o_dbus_oe), .o_ctl_out(o_ctl_out), .o_ctl_oe(o_ctl_oe), .o_addr(o_addr),
    .o_fifo_adv(o_fifo_adv), .o_wave_int(o_wave_int), .o_done_int(o_done_int),
    .o_done(o_done), .o_state(o_state));
  pwe_periph i_pwe_periph (.i_clk(i_clk), .i_dbus_out(o_dbus_out), .i_dbus_oe(o_dbus_oe),
    .i_ready_req(ready_req), .o_ready(i_ready), .o_dbus_in(i_dbus_in));
  // ==========================================================
  // Checking and closing
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Ceiling well above the fewer than 200 cycles the sequence needs
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  // ==========================================================
  // Register port
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk("rd_data", 16'(o_rd_data), 16'(exp));
  endtask
  task automatic load(input int d, input int s, input logic [31:0] ins);
    for (int b = 0; b < 4; b++) begin
      wr(MEM_BASE + 16'(d * 32 + s * 4 + b), ins[8*b+:8]);
    end
  endtask
  task automatic wait_done;
    for (int n = 0; n < 20 && o_done !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    chk("done", 16'(o_done), 16'h1);
  endtask
  task automatic settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    settle();
    chk("state", 16'(o_state), 16'h7);
    chk("ctl_oe", 16'(o_ctl_oe), 16'h3f);
    chk("ctl", 16'(o_ctl_out), 16'h3f);
    rd(ISC_ADDR, 8'h80);
    rd(ICL_ADDR, ICL_RST);
    rd(CCFG_ADDR, CCFG_RST);
    rd(WFSEL_ADDR, WFSEL_RST);
    rd(16'he4ff, 8'h00);
    // Descriptors closed outside waveform mode
    wr(MEM_BASE, 8'haa);
    rd(MEM_BASE, 8'h00);
    wr(TRIG_ADDR, 8'h00);
    settle();
    chk("done", 16'(o_done), 16'h1);
    // Firmware loads everything before triggering
    wr(IFSEL_ADDR, 8'(IFSEL_WAVE));
    wr(MEM_BASE, 8'ha5);
    rd(MEM_BASE, 8'ha5);
    load(0, 0, 32'h3e000200);
    load(0, 1, 32'h3f000120);
    for (int s = 2; s < 7; s++) begin
      load(0, s, 32'h3f000100);
    end
    wr(DOL_ADDR, 8'h34);
    wr(DOH_ADDR, 8'h12);
    wr(TRIG_ADDR, 8'h00);
    for (int i = 0; i < 9; i++) begin
      #1;
      chk("state", 16'(o_state), 16'(exp_st[i]));
      if (i == 0) chk("done", 16'(o_done), 16'h0);
      if (i == 0) chk("ctl", 16'(o_ctl_out), 16'h3e);
      if (i == 2) chk("data_oe", 16'(o_dbus_oe), 16'h1);
      if (i == 8) chk("done_int", 16'(o_done_int), 16'h1);
      @(posedge i_clk);
    end
    #1;
    chk("data_oe", 16'(o_dbus_oe), 16'h0);
    wr(ISC_ADDR, 8'h01);
    settle();
    chk("data_oe", 16'(o_dbus_oe), 16'h1);
    chk("data", o_dbus_out, 16'h1234);
    rd(ISC_ADDR, 8'h81);
    // Decision state loops on ready line 0 or the FIFO flag, else goes idle
    wr(MEM_BASE + 16'h0024, 8'h00);
    load(1, 0, 32'hff6078bc);
    ready_req <= 6'h01;
    wr(TRIG_ADDR, 8'h01);
    #1;
    chk("fifo_adv", 16'(o_fifo_adv), 16'h1);
    chk("wave_int", 16'(o_wave_int), 16'h1);
    repeat (6) @(posedge i_clk);
    #1;
    chk("state", 16'(o_state), 16'h0);
    chk("fifo_adv", 16'(o_fifo_adv), 16'h0);
    ready_req <= 6'h00;
    wait_done();
    // Abort in mid-waveform; the FIFO flag term now holds the loop
    fifo_flag <= 1'b1;
    wr(TRIG_ADDR, 8'h01);
    // Firmware reads status while busy, then writes the abort
    rd(TRIG_ADDR, 8'h01);
    chk("state", 16'(o_state), 16'h0);
    wr(ABORT_ADDR, 8'h00);
    @(posedge i_clk);
    #1;
    chk("done", 16'(o_done), 16'h1);
    chk("state", 16'(o_state), 16'h7);
    chk("addr", 16'(o_addr), 16'h2);
    fifo_flag <= 1'b0;
    // Open drain and tristate control modes
    wr(CCFG_ADDR, 8'h01);
    settle();
    chk("ctl_oe", 16'(o_ctl_oe), 16'h3e);
    wr(CCFG_ADDR, 8'h80);
    wr(ICL_ADDR, 8'h5a);
    settle();
    chk("ctl_oe", 16'(o_ctl_oe), 16'h05);
    chk("ctl", 16'(o_ctl_out[3:0]), 16'ha);
    summarize();
  end
endmodule
`default_nettype wire
